// ===== rtl/asp_bitclk.sv
// bit clock selection and divider for the serial audio port
`default_nettype none

module asp_bitclk
  import asp_pkg::*;
#(
  parameter int DIV_WIDTH = 3
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // synchronised clock sources
  input  wire logic                 pin_clock,
  input  wire logic                 codec_clock,
  // selection
  input  wire logic                 direction,
  input  wire logic [DIV_WIDTH-1:0] divider,
  // selected bit clock and its rising-edge pulse
  output var  logic                 bit_clock,
  output var  logic                 tick
);

  logic [DIV_WIDTH-1:0] div_count;
  logic [DIV_WIDTH-1:0] next_div_count;
  logic                 divided;
  logic                 next_divided;
  logic                 codec_last;
  logic                 codec_edge;
  logic                 next_clock;
  logic                 next_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // divider counts codec edges, source select, edge detect
  always_comb begin
    next_div_count = div_count;
    next_divided   = divided;
    codec_edge     = codec_clock != codec_last;
    if (codec_edge) begin
      if (div_count >= divider) begin
        next_div_count = '0;
        next_divided   = ~divided;                      // [RL9]
      end else begin
        next_div_count = DIV_WIDTH'(div_count + 1'b1);
      end
    end
    next_clock = direction ? divided : pin_clock;       // [RL8] [RL9]
    next_tick  = next_clock & ~bit_clock;
  end

  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      div_count  <= '0;
      divided    <= 1'b0;
      codec_last <= 1'b0;
      bit_clock  <= 1'b0;
      tick       <= 1'b0;
    end else begin
      div_count  <= next_div_count;
      divided    <= next_divided;
      codec_last <= codec_clock;
      bit_clock  <= next_clock;
      tick       <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_slave_follow: assert property (@(posedge clock) disable iff (rst) // [RL8]
    !direction && !$past(direction) && $rose(pin_clock) |=> bit_clock && tick)
    else $error("slave bit clock did not follow the pin");

  a_master_divide: assert property (@(posedge clock) disable iff (rst) // [RL9]
    direction && codec_edge && div_count >= divider |=> divided != $past(divided)
      ##1 (bit_clock == $past(divided) || !$past(direction)))
    else $error("master divider did not toggle at the ratio");

endmodule // asp_bitclk

`default_nettype wire

// ===== rtl/asp_pkg.sv
// constants, register layouts and modes for the serial audio port control block
//
// What this block does
// RL1 - After reset release the port sits in configuration mode until software turns it on.
// RL2 - Writing the module-on bit to one moves the port from configuration into enabled mode.
// RL3 - Data flow is serviced by DMA requests or interrupts, and errors raise an interrupt.
// RL4 - Only two words are buffered, so each must be serviced once per system word period.
// RL5 - While turning off, the outside party keeps the bit clock running until idle shows.
// RL6 - On underflow or overflow the channel and system-word indices show the next position.
// RL7 - Software resynchronises with the two indices by skipping or padding samples.
// RL8 - With bit-clock direction at 0 the shift register runs from the bit-clock pin input.
// RL9 - With bit-clock direction at 1 the shift clock is the divided codec bit clock input.
// RL10 - In either direction the bit-clock pin output equals the shift register's bit clock.
// RL11 - Left and right received words share one 32-bit buffer, so overflow shifts slots.
// RL12 - Receive overflow sets the overflow flag and interrupt; writing 0 clears the flag.
// RL13 - After receive DMA overflow software turns module and DMA off, clears and restarts.
// RL14 - After module-on clears, the port ends the system word, stops and sets idle flag.
// RL15 - Once idle the port shows disabled mode until module-on is written to one again.
`default_nettype none

package asp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_TX_DATA = 4'h8;
  localparam logic [3:0] ADDR_RX_DATA = 4'hC;

  // reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;

  // data word length codes; code 3 is treated as 32 bits too
  localparam logic [1:0] DWL_8  = 2'h0;
  localparam logic [1:0] DWL_16 = 2'h1;
  localparam logic [1:0] DWL_32 = 2'h2;

  // last bit position of a 32-bit system word
  localparam logic [4:0] SYSTEM_WORD_LAST = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////////
  // operation modes
  typedef enum logic [1:0] {
    MODE_CONFIG,
    MODE_ENABLED,
    MODE_STOPPING,
    MODE_DISABLED
  } asp_mode_type;

  // control register layout
  typedef struct packed {
    logic [19:0] reserved;
    logic        data_irq_enable;
    logic        idle_irq_enable;
    logic        error_irq_enable;
    logic [2:0]  bit_clock_divider;
    logic [1:0]  data_word_length;
    logic        bit_clock_direction;
    logic        dma_request_on;
    logic        transmit;
    logic        module_on;
  } asp_control_type;

  // status register layout
  typedef struct packed {
    logic [20:0]  reserved;
    asp_mode_type mode;
    logic         system_word_index;
    logic [1:0]   channel_index;
    logic         rx_full;
    logic         tx_full;
    logic         dma_end_flag;
    logic         underflow_flag;
    logic         overflow_flag;
    logic         idle_flag;
  } asp_status_type;

endpackage : asp_pkg

`default_nettype wire

// ===== rtl/asp_port.sv
// serial audio port: mode control, data servicing, bit clock and error recovery
//
// The placing of the registers and the strobed register port were decided locally.
`default_nettype none

module asp_port
  import asp_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // register port
  input  wire logic [3:0]  ADDRESS,
  input  wire logic [31:0] WRITE_DATA,
  input  wire logic        WRITE_STROBE,
  input  wire logic        READ_STROBE,
  output var  logic [31:0] READ_DATA,
  // dma and interrupt
  output var  logic        DMA_TX_REQUEST,
  output var  logic        DMA_RX_REQUEST,
  input  wire logic        DMA_TRANSFER_END,
  output var  logic        IRQ,
  // clock pins
  input  wire logic        AUDIO_CODEC_BIT_CLOCK_IN,
  input  wire logic        BIT_CLOCK_PIN_IN,
  output var  logic        BIT_CLOCK_PIN_OUT,
  output var  logic        BIT_CLOCK_PIN_OE,
  // word select and data pins
  input  wire logic        WORD_SELECT_IN,
  output var  logic        WORD_SELECT_OUT,
  output var  logic        WORD_SELECT_OE,
  input  wire logic        SERIAL_DATA_IN,
  output var  logic        SERIAL_DATA_OUT,
  output var  logic        SERIAL_DATA_OE
);

  asp_control_type ctrl, next_ctrl, wr_ctrl;
  asp_status_type  status, wr_status;
  asp_mode_type    mode, next_mode;
  logic [2:0]      pins_s;
  logic            pin_clock_s, codec_clock_s, ws_s, sdi_s;
  logic            bit_clock, tick, shift_tick, active, entering;
  logic            ctrl_write, status_write, tx_write, rx_read;
  logic            idle, next_idle, ovf, next_ovf, unf, next_unf, dma_end, next_dma_end;
  logic [31:0]     tx_buf, next_tx_buf, rx_buf, next_rx_buf, shift, next_shift;
  logic [31:0]     loaded, src, rx_word, rx_mask;
  logic            tx_full, next_tx_full, rx_full, next_rx_full;
  logic [4:0]      bit_count, next_bit_count, eff_count, word_mask, tx_lead;
  logic            sys_index, next_sys_index, ws_last, next_ws_last, sdo, next_sdo;
  logic            frame_restart, word_start, word_end, sys_end, tx_load, rx_store;
  logic [1:0]      channel_index;
  logic [31:0]     next_read_data;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bit clock
  asp_sync #(.WIDTH(3)) u_clk_sync (
    .clock    (CLOCK),
    .rst      (RST),
    .async_in ({BIT_CLOCK_PIN_IN, AUDIO_CODEC_BIT_CLOCK_IN, WORD_SELECT_IN}),
    .sync_out (pins_s)
  );

  asp_sync #(.WIDTH(1)) u_data_sync (
    .clock    (CLOCK),
    .rst      (RST),
    .async_in (SERIAL_DATA_IN),
    .sync_out (sdi_s)
  );

  assign pin_clock_s   = pins_s[2];
  assign codec_clock_s = pins_s[1];
  assign ws_s          = pins_s[0];

  asp_bitclk #(.DIV_WIDTH(3)) u_bitclk (
    .clock       (CLOCK),
    .rst         (RST),
    .pin_clock   (pin_clock_s),
    .codec_clock (codec_clock_s),
    .direction   (ctrl.bit_clock_direction),
    .divider     (ctrl.bit_clock_divider),
    .bit_clock   (bit_clock),
    .tick        (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  always_comb begin
    ctrl_write   = WRITE_STROBE && ADDRESS == ADDR_CONTROL;
    status_write = WRITE_STROBE && ADDRESS == ADDR_STATUS;
    tx_write     = WRITE_STROBE && ADDRESS == ADDR_TX_DATA;
    rx_read      = READ_STROBE && ADDRESS == ADDR_RX_DATA;
    wr_ctrl      = asp_control_type'(WRITE_DATA);
    wr_status    = asp_status_type'(WRITE_DATA);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register and operation mode
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    if (ctrl_write) begin
      next_ctrl          = wr_ctrl;
      next_ctrl.reserved = '0;
    end
    case (mode)
      MODE_CONFIG, MODE_DISABLED: begin
        if (ctrl_write && wr_ctrl.module_on) begin
          next_mode = MODE_ENABLED;                     // [RL1] [RL2] [RL15]
        end
      end
      MODE_ENABLED: begin
        if (!ctrl.module_on) begin
          next_mode = MODE_STOPPING;                    // [RL14]
        end
      end
      MODE_STOPPING: begin
        if (shift_tick && sys_end) begin
          next_mode = MODE_DISABLED;                    // [RL14] [RL5]
        end
      end
      default: next_mode = MODE_CONFIG;
    endcase
  end

  // control registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl <= asp_control_type'(CONTROL_RESET);
      mode <= MODE_CONFIG;                              // [RL1]
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word geometry from the data word length
  always_comb begin
    case (ctrl.data_word_length)
      DWL_8: begin
        word_mask     = 5'h07;
        tx_lead       = 5'h18;
        rx_mask       = 32'h0000_00FF;
        channel_index = eff_count[4:3];
      end
      DWL_16: begin
        word_mask     = 5'h0F;
        tx_lead       = 5'h10;
        rx_mask       = 32'h0000_FFFF;
        channel_index = {1'b0, eff_count[4]};
      end
      default: begin
        word_mask     = 5'h1F;
        tx_lead       = 5'h00;
        rx_mask       = 32'hFFFF_FFFF;
        channel_index = 2'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shift position, buffers and error flags
  always_comb begin
    active        = mode == MODE_ENABLED || mode == MODE_STOPPING;
    entering      = next_mode == MODE_ENABLED && mode != MODE_ENABLED;
    shift_tick    = active && tick;
    frame_restart = !ctrl.bit_clock_direction && ws_s != ws_last;
    eff_count     = frame_restart ? 5'h00 : bit_count;
    word_start    = (eff_count & word_mask) == 5'h00;
    word_end      = (eff_count & word_mask) == word_mask;
    sys_end       = eff_count == SYSTEM_WORD_LAST;
    tx_load       = shift_tick && ctrl.transmit && word_start;
    rx_store      = shift_tick && !ctrl.transmit && word_end;
    loaded        = tx_full ? tx_buf << tx_lead : DATA_RESET;
    src           = tx_load ? loaded : shift;
    rx_word       = {shift[30:0], sdi_s} & rx_mask;
    next_shift    = shift_tick ? {src[30:0], sdi_s} : shift;
    next_sdo      = (shift_tick && ctrl.transmit) ? src[31] : sdo;
    next_ws_last  = shift_tick ? ws_s : ws_last;
    next_bit_count = bit_count;
    next_sys_index = sys_index;
    if (entering) begin
      next_bit_count = 5'h00;
      next_sys_index = 1'b0;
    end else if (shift_tick) begin
      next_bit_count = 5'(eff_count + 1'b1);
      next_sys_index = ctrl.bit_clock_direction ? (sys_index ^ sys_end) : ws_s;
    end
    // two-word buffering: holding word plus shift register
    next_tx_buf  = tx_write ? WRITE_DATA : tx_buf;      // [RL4]
    next_tx_full = tx_write ? 1'b1 : (tx_load ? 1'b0 : tx_full);
    // one shared receive word; an unread word is replaced so channels slip
    next_rx_buf  = rx_store ? rx_word : rx_buf;         // [RL11]
    next_rx_full = rx_store ? 1'b1 : (rx_read ? 1'b0 : rx_full);
    // flags clear on written 0, a same-cycle event wins
    next_unf     = (status_write && !wr_status.underflow_flag) ? 1'b0 : unf;
    next_ovf     = (status_write && !wr_status.overflow_flag) ? 1'b0 : ovf;    // [RL12]
    next_dma_end = (status_write && !wr_status.dma_end_flag) ? 1'b0 : dma_end;
    next_idle    = (status_write && !wr_status.idle_flag) ? 1'b0 : idle;
    if (tx_load && !tx_full) begin
      next_unf = 1'b1;                                  // [RL3]
    end
    if (rx_store && rx_full && !rx_read) begin
      next_ovf = 1'b1;                                  // [RL12] [RL3]
    end
    if (DMA_TRANSFER_END) begin
      next_dma_end = 1'b1;                              // [RL3]
    end
    if (mode == MODE_STOPPING && shift_tick && sys_end) begin
      next_idle = 1'b1;                                 // [RL14]
    end
  end

  // datapath registers
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tx_buf    <= DATA_RESET;
      tx_full   <= 1'b0;
      rx_buf    <= DATA_RESET;
      rx_full   <= 1'b0;
      shift     <= DATA_RESET;
      bit_count <= 5'h00;
      sys_index <= 1'b0;
      ws_last   <= 1'b0;
      sdo       <= 1'b0;
      unf       <= 1'b0;
      ovf       <= 1'b0;
      dma_end   <= 1'b0;
      idle      <= 1'b0;
    end else begin
      tx_buf    <= next_tx_buf;
      tx_full   <= next_tx_full;
      rx_buf    <= next_rx_buf;
      rx_full   <= next_rx_full;
      shift     <= next_shift;
      bit_count <= next_bit_count;
      sys_index <= next_sys_index;
      ws_last   <= next_ws_last;
      sdo       <= next_sdo;
      unf       <= next_unf;
      ovf       <= next_ovf;
      dma_end   <= next_dma_end;
      idle      <= next_idle;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status view and read data
  always_comb begin
    status                   = '0;
    status.mode              = mode;                    // [RL15]
    status.system_word_index = sys_index;               // [RL6]
    status.channel_index     = channel_index;           // [RL6]
    status.rx_full           = rx_full;
    status.tx_full           = tx_full;
    status.dma_end_flag      = dma_end;
    status.underflow_flag    = unf;
    status.overflow_flag     = ovf;
    status.idle_flag         = idle;
    next_read_data           = 32'h0000_0000;
    if (READ_STROBE) begin
      case (ADDRESS)
        ADDR_CONTROL: next_read_data = ctrl;
        ADDR_STATUS:  next_read_data = status;
        ADDR_TX_DATA: next_read_data = tx_buf;
        ADDR_RX_DATA: next_read_data = rx_buf;
        default:      next_read_data = 32'h0000_0000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      READ_DATA <= 32'h0000_0000;
    end else begin
      READ_DATA <= next_read_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // requests, interrupt and pins
  always_comb begin
    DMA_TX_REQUEST    = active && ctrl.dma_request_on && ctrl.transmit && !tx_full; // [RL3]
    DMA_RX_REQUEST    = active && ctrl.dma_request_on && !ctrl.transmit && rx_full;
    IRQ               = (ctrl.error_irq_enable && (ovf || unf || dma_end))          // [RL3]
                      || (ctrl.idle_irq_enable && idle)                             // [RL14]
                      || (ctrl.data_irq_enable && active && !ctrl.dma_request_on
                          && (ctrl.transmit ? !tx_full : rx_full));
    BIT_CLOCK_PIN_OUT = bit_clock;                      // [RL10]
    BIT_CLOCK_PIN_OE  = ctrl.bit_clock_direction;
    WORD_SELECT_OUT   = sys_index;
    WORD_SELECT_OE    = active && ctrl.bit_clock_direction;
    SERIAL_DATA_OUT   = sdo;
    SERIAL_DATA_OE    = active && ctrl.transmit;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  a_reset_config: assert property (@(posedge CLOCK) // [RL1]
    $past(RST) && !RST |-> mode == MODE_CONFIG && !active)
    else $error("port not in configuration mode after reset");

  a_enable_entry: assert property (@(posedge CLOCK) disable iff (RST) // [RL2]
    (mode == MODE_CONFIG || mode == MODE_DISABLED) && ctrl_write && wr_ctrl.module_on
      |=> mode == MODE_ENABLED && bit_count == 5'h00)
    else $error("module-on write did not enable the port");

  a_underflow_set: assert property (@(posedge CLOCK) disable iff (RST) // [RL3]
    tx_load && !tx_full |=> unf && !sdo)
    else $error("empty transmit load did not flag underflow");

  a_tx_consume: assert property (@(posedge CLOCK) disable iff (RST) // [RL4]
    tx_load && tx_full && !tx_write |=> !tx_full && sdo == $past(loaded[31]))
    else $error("transmit word not moved into the shift register");

  a_rx_overwrite: assert property (@(posedge CLOCK) disable iff (RST) // [RL11]
    rx_store && rx_full && !rx_read |=> ovf && rx_buf == $past(rx_word))
    else $error("overflowing word did not take the shared slot");

  a_overflow_clear: assert property (@(posedge CLOCK) disable iff (RST) // [RL12]
    status_write && !wr_status.overflow_flag && !rx_store |=> !ovf)
    else $error("overflow flag not cleared by writing 0");

  a_stop_word: assert property (@(posedge CLOCK) disable iff (RST) // [RL14]
    mode == MODE_STOPPING && shift_tick && sys_end |=> mode == MODE_DISABLED && idle
      ##1 !SERIAL_DATA_OE)
    else $error("port did not go idle at the end of the system word");

  a_disabled_hold: assert property (@(posedge CLOCK) disable iff (RST) // [RL15]
    mode == MODE_DISABLED && !(ctrl_write && wr_ctrl.module_on) |=> mode == MODE_DISABLED)
    else $error("port left disabled mode without a module-on write");

  a_clock_pin: assert property (@(posedge CLOCK) disable iff (RST) // [RL10]
    tick |-> $rose(BIT_CLOCK_PIN_OUT))
    else $error("shift tick not matched by the bit-clock pin");

endmodule // asp_port

`default_nettype wire

// ===== rtl/asp_sync.sv
// two-flop synchroniser for pin inputs
`default_nettype none

module asp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // asynchronous inputs and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  ////////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule // asp_sync

`default_nettype wire

// ===== test/asp_codec_model.sv
// far-side audio device model: clocks, word select and serial data
`default_nettype none

module asp_codec_model (
  // clock sources
  output var logic codec_clock,
  output var logic pin_clock,
  // frame and data lines
  output var logic word_select,
  output var logic serial_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] bit_count;

  ////////////////////////////////////////////////////////////////////////////////
  // clocks run free, so a stopping port can always finish its word
  initial begin
    codec_clock = 1'b0;
    pin_clock   = 1'b0;
    word_select = 1'b0;
    serial_data = 1'b0;
    bit_count   = 5'h00;
  end
  always #30 codec_clock = ~codec_clock;
  always #40 pin_clock = ~pin_clock;

  // data changes on the falling edge, word select every 32 bits
  always @(negedge pin_clock) begin
    bit_count   <= bit_count + 5'h01;
    serial_data <= 1'($urandom);
    if (bit_count == 5'h1F) begin
      word_select <= ~word_select;
    end
  end
endmodule // asp_codec_model

`default_nettype wire

// ===== test/audio_serial_port_control_tb_top.sv
// self-checking bench for the serial audio port control block
`default_nettype none

module audio_serial_port_control_tb_top
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock, rst, wstb, rstb, dma_end, rd_seen, bprev;
  logic        dma_tx, irq, ck_codec, ck_pin, ws_in, sd_in, bck_out, bck_oe;
  logic        dma_rx, ws_out, ws_oe, sd_out, sd_oe;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, last_rd, txw, sreg;
  logic [63:0] n;
  logic [63:0] notes[$];
  logic [2:0]  d;
  int          p, mismatches, compares;

  asp_port asp_port_i (.CLOCK(clock), .RST(rst), .ADDRESS(addr), .WRITE_DATA(wdata),
    .WRITE_STROBE(wstb), .READ_STROBE(rstb), .READ_DATA(rdata), .DMA_TX_REQUEST(dma_tx),
    .DMA_RX_REQUEST(dma_rx), .DMA_TRANSFER_END(dma_end), .IRQ(irq),
    .AUDIO_CODEC_BIT_CLOCK_IN(ck_codec), .BIT_CLOCK_PIN_IN(ck_pin),
    .BIT_CLOCK_PIN_OUT(bck_out), .BIT_CLOCK_PIN_OE(bck_oe), .WORD_SELECT_IN(ws_in),
    .WORD_SELECT_OUT(ws_out), .WORD_SELECT_OE(ws_oe), .SERIAL_DATA_IN(sd_in),
    .SERIAL_DATA_OUT(sd_out), .SERIAL_DATA_OE(sd_oe));
  asp_codec_model asp_codec_model_i (.codec_clock(ck_codec), .pin_clock(ck_pin),
    .word_select(ws_in), .serial_data(sd_in));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and comparison tasks
  always #5 clock = ~clock;

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_pin(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // read watcher takes the oldest note when read data stands
  always @(posedge clock) rd_seen <= rstb;
  always @(posedge clock) bprev <= bck_out;
  always @(negedge clock) begin
    if (rd_seen) begin
      last_rd = rdata;
      n = notes.pop_front();
      if (n[31:0] != 32'h0) cmp(n[63:32], rdata & n[31:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register bus tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wstb  <= 1'b1;
    @(posedge clock);
    wstb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    addr <= a;
    rstb <= 1'b1;
    notes.push_back({e & m, m});
    @(posedge clock);
    rstb <= 1'b0;
    @(posedge clock);
  endtask

  // poll status until the masked bits match, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] w);
    int k;
    k = 0;
    do begin
      rd(ADDR_STATUS, 32'h0, 32'h0);
      k++;
    end while ((last_rd & m) !== w && k < 2000);
    cmp(w, last_rd & m);
  endtask

  // cycles between two rises of the bit clock pin output
  task automatic period(output int q);
    repeat (3) begin
      q = 0;
      do begin
        @(posedge clock);
        #1;
        q++;
      end while (!(bck_out === 1'b1 && bprev === 1'b0) && q < 200);
    end
  endtask

  task automatic conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #600000;
    mismatches++;
    conclude();
  end

  // main sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wstb = 1'b0;
    rstb = 1'b0;
    dma_end = 1'b0;
    void'($urandom(32'hE57720DA));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_CONTROL, CONTROL_RESET, 32'hFFFFFFFF);
    rd(ADDR_STATUS, 32'h0, 32'h63F);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    d = 3'($urandom_range(7));
    wr(ADDR_CONTROL, {23'h0, d, 6'h08});
    period(p);
    cmp(32'(6 * (d + 1)), 32'(p));
    cmp_pin(1'b1, bck_oe);
    wr(ADDR_CONTROL, 32'h0);
    period(p);
    cmp(32'h8, 32'(p));
    cmp_pin(1'b0, bck_oe);
    $display("test bit clock done");
    wr(ADDR_CONTROL, 32'h225);
    rd(ADDR_STATUS, 32'h200, 32'h600);
    poll(32'h2, 32'h2);
    cmp_pin(1'b1, irq);
    cmp_pin(1'b1, dma_rx);
    cmp_pin(1'b0, sd_oe);
    rd(ADDR_STATUS, 32'h0, 32'hC0);
    wr(ADDR_CONTROL, 32'h220);
    poll(32'h601, 32'h601);
    cmp_pin(1'b0, dma_rx);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS, 32'h600, 32'h60F);
    cmp_pin(1'b0, irq);
    $display("test overflow done");
    wr(ADDR_CONTROL, 32'h227);
    rd(ADDR_STATUS, 32'h200, 32'h600);
    cmp_pin(1'b1, dma_tx);
    cmp_pin(1'b1, sd_oe);
    cmp_pin(1'b0, ws_oe);
    txw = $urandom;
    wr(ADDR_TX_DATA, txw);
    #1;
    cmp_pin(1'b0, dma_tx);
    // the request returns when the word is loaded; capture it at falling bit clock edges
    wait (dma_tx === 1'b1);
    for (int i = 0; i < 32; i++) begin
      @(negedge bck_out);
      sreg = {sreg[30:0], sd_out};
      if (i == 15) cmp_pin(ws_in, ws_out);
    end
    cmp(txw, sreg);
    poll(32'h4, 32'h4);
    cmp_pin(1'b1, irq);
    @(posedge clock);
    dma_end <= 1'b1;
    @(posedge clock);
    dma_end <= 1'b0;
    rd(ADDR_STATUS, 32'h8, 32'h8);
    wr(ADDR_CONTROL, 32'h0);
    poll(32'h601, 32'h601);
    $display("test transmit done");
    conclude();
  end
endmodule // audio_serial_port_control_tb_top

`default_nettype wire
